// ### design/change_event_consts.vh
/*
 constants of the descriptor change event builder: list formats, group operations,
 store depth, payload limit and field widths. included by both design modules.
*/
`ifndef CHANGE_EVENT_CONSTS_VH
`define CHANGE_EVENT_CONSTS_VH

// list_format codes, ordinals from zero
`define FMT_REFRESH_WHOLE_STORE 8'h00
`define FMT_LIST_BY_RECORD_TYPE 8'h01
`define FMT_LIST_BY_RECORD_HANDLE 8'h02

// group_operation codes, ordinals from zero, also the emission order
`define OP_REFRESH_LISTED_TYPES 2'h0
`define OP_DELETED 2'h1
`define OP_ADDED 2'h2
`define OP_MODIFIED 2'h3

// change items held for one message
`define ITEM_DEPTH 5'h10
// baseline transmission unit available to the payload, in bytes
`define PAYLOAD_LIMIT_BYTES 16'h003c
// fixed payload header: list_format byte and change_group_count byte
`define HEADER_BYTES 16'h0002
// per group: operation byte and entry_count byte
`define GROUP_HEADER_BYTES 16'h0002
`define ITEM_BYTES 16'h0004

// reset values
`define FLOOR_RESET 2'h1
`define COUNT_RESET 8'h00

`endif

// ### design/payload_size_calc.v
/*
 payload length calculator: total byte count of a change event payload from the
 four per-operation entry counts. assumes counts stay within the item store depth.
*/
`timescale 1ns/100ps
`include "change_event_consts.vh"

module payload_size_calc (
   // per-operation entry counts
   input wire [7:0] cnt_refresh,
   input wire [7:0] cnt_deleted,
   input wire [7:0] cnt_added,
   input wire [7:0] cnt_modified,
   // resulting payload length
   output reg [15:0] total_bytes
);

   function [15:0] group_bytes;
      input [7:0] cnt;
      begin
         if (cnt == `COUNT_RESET)
            group_bytes = 16'h0000;
         else
            group_bytes = `GROUP_HEADER_BYTES + {6'h00, cnt, 2'h0};
      end
   endfunction

   always @* begin
      total_bytes = `HEADER_BYTES + group_bytes(cnt_refresh) + group_bytes(cnt_deleted)
                    + group_bytes(cnt_added) + group_bytes(cnt_modified);
   end

endmodule

// ### design/descriptor_change_event_builder.v
/*
 descriptor change event builder: collects change items for one repository change
 event and streams its payload bytes, groups in operation order, entries lsb first.
 assumes the downstream transport adds headers and framing and honours out_last.
*/
`timescale 1ns/100ps
`include "change_event_consts.vh"

module descriptor_change_event_builder (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // message composition
   input wire start,
   input wire [7:0] start_format,
   input wire series_start,
   input wire send,
   output wire busy,
   output reg fell_back_q,
   // change items
   input wire item_valid,
   input wire [1:0] item_op,
   input wire [31:0] item_value,
   output wire item_ready,
   output reg item_err_q,
   // payload byte stream
   output reg out_valid_q,
   output reg [7:0] out_data_q,
   output reg out_last_q,
   input wire out_ready
);

   localparam S_IDLE = 4'h0;
   localparam S_FILL = 4'h1;
   localparam S_FMT = 4'h2;
   localparam S_CNT = 4'h3;
   localparam S_OP = 4'h4;
   localparam S_ECNT = 4'h5;
   localparam S_SCAN = 4'h6;
   localparam S_BYTE = 4'h7;
   localparam S_DRAIN = 4'h8;
   reg [3:0] state_q, state_d;
   reg [7:0] fmt_q, fmt_d, out_data_d;
   reg [1:0] floor_q, floor_d, op_q, op_d, sel_q, sel_d;
   reg [4:0] n_q, n_d, scan_q, scan_d;
   reg [15:0] idx_q, idx_d, total_q, total_d;
   reg [7:0] cnt_q [0:3];
   reg [7:0] cnt_d [0:3];
   reg fell_back_d, item_err_d, out_valid_d, out_last_d;
   reg [31:0] mem_val [0:15];
   reg [1:0] mem_op [0:15];
   wire [3:0] nz;
   wire [15:0] size_now;
   wire [2:0] groups;
   wire can_load, last_byte, take, refuse;
   integer i, j;
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_nz
         assign nz[g] = (cnt_q[g] != `COUNT_RESET);
      end
   endgenerate
   payload_size_calc u_size (
      .cnt_refresh(cnt_q[0]),
      .cnt_deleted(cnt_q[1]),
      .cnt_added(cnt_q[2]),
      .cnt_modified(cnt_q[3]),
      .total_bytes(size_now)
   );
   // lowest operation at or above from that holds entries
   function [1:0] next_op;
      input [3:0] mask;
      input [2:0] from;
      integer k;
      begin
         next_op = 2'h3;
         for (k = 3; k >= 0; k = k - 1) begin
            if (mask[k] && (k[2:0] >= from))
               next_op = k[1:0];
         end
      end
   endfunction
   function [7:0] item_byte;
      input [31:0] v;
      input [1:0] sel;
      begin
         item_byte = v[{sel, 3'h0} +: 8];
      end
   endfunction

   assign groups = {2'h0, nz[0]} + {2'h0, nz[1]} + {2'h0, nz[2]} + {2'h0, nz[3]};
   assign can_load = !out_valid_q || out_ready;
   assign last_byte = (idx_q == total_q - 16'h0001);
   assign busy = (state_q != S_IDLE) && (state_q != S_FILL);
   // send in the same cycle stalls the item so counts are settled at the size check
   assign item_ready = (state_q == S_FILL) && (n_q != `ITEM_DEPTH) && !send;
   assign take = item_valid && item_ready;
   assign refuse = (fmt_q == `FMT_REFRESH_WHOLE_STORE)
                   || ((item_op == `OP_REFRESH_LISTED_TYPES)
                       && (fmt_q != `FMT_LIST_BY_RECORD_TYPE))
                   || ((item_op != `OP_REFRESH_LISTED_TYPES) && (item_op < floor_q));

   always @* begin
      state_d = state_q;
      fmt_d = fmt_q;
      floor_d = floor_q;
      n_d = n_q;
      scan_d = scan_q;
      op_d = op_q;
      sel_d = sel_q;
      idx_d = idx_q;
      total_d = total_q;
      for (i = 0; i < 4; i = i + 1)
         cnt_d[i] = cnt_q[i];
      fell_back_d = fell_back_q;
      item_err_d = 1'b0;
      out_valid_d = out_valid_q;
      out_last_d = out_last_q;
      out_data_d = out_data_q;
      if (out_valid_q && out_ready) begin
         out_valid_d = 1'b0;
         out_last_d = 1'b0;
      end
      if (series_start)
         floor_d = `FLOOR_RESET;
      case (state_q)
         S_IDLE: begin
            if (start) begin
               fmt_d = start_format;
               n_d = 5'h00;
               for (i = 0; i < 4; i = i + 1)
                  cnt_d[i] = `COUNT_RESET;
               fell_back_d = 1'b0;
               state_d = S_FILL;
            end
         end
         S_FILL: begin
            if (take && refuse)
               item_err_d = 1'b1;
            else if (take) begin
               cnt_d[item_op] = cnt_q[item_op] + 8'h01;
               n_d = n_q + 5'h01;
            end
            if (send) begin
               idx_d = 16'h0000;
               if (size_now > `PAYLOAD_LIMIT_BYTES) begin
                  fell_back_d = 1'b1;
                  fmt_d = `FMT_REFRESH_WHOLE_STORE;
                  total_d = `HEADER_BYTES;
               end else begin
                  total_d = (fmt_q == `FMT_REFRESH_WHOLE_STORE) ? `HEADER_BYTES : size_now;
                  if (nz[3])
                     floor_d = `OP_MODIFIED;
                  else if (nz[2])
                     floor_d = `OP_ADDED;
                  else if (nz[1] && !series_start)
                     floor_d = (floor_q > `OP_DELETED) ? floor_q : `OP_DELETED;
               end
               state_d = S_FMT;
            end
         end
         S_FMT: begin
            if (can_load) begin
               out_valid_d = 1'b1;
               out_data_d = fmt_q;
               out_last_d = last_byte;
               idx_d = idx_q + 16'h0001;
               state_d = S_CNT;
            end
         end
         S_CNT: begin
            if (can_load) begin
               // group count, zero on whole refresh
               out_valid_d = 1'b1;
               out_data_d = (fmt_q == `FMT_REFRESH_WHOLE_STORE) ? 8'h00 : {5'h00, groups};
               out_last_d = last_byte;
               idx_d = idx_q + 16'h0001;
               if (last_byte)
                  state_d = S_DRAIN;
               else begin
                  op_d = next_op(nz, 3'h0);
                  state_d = S_OP;
               end
            end
         end
         S_OP: begin
            if (can_load) begin
               out_valid_d = 1'b1;
               out_data_d = {6'h00, op_q};
               out_last_d = last_byte;
               idx_d = idx_q + 16'h0001;
               state_d = S_ECNT;
            end
         end
         S_ECNT: begin
            if (can_load) begin
               out_valid_d = 1'b1;
               out_data_d = cnt_q[op_q];
               out_last_d = last_byte;
               idx_d = idx_q + 16'h0001;
               scan_d = 5'h00;
               state_d = S_SCAN;
            end
         end
         S_SCAN: begin
            // linear search trades cycles for not sorting the item store
            if (scan_q == n_q) begin
               op_d = next_op(nz, {1'b0, op_q} + 3'h1);
               state_d = S_OP;
            end else if (mem_op[scan_q[3:0]] == op_q) begin
               sel_d = 2'h0;
               state_d = S_BYTE;
            end else begin
               scan_d = scan_q + 5'h01;
            end
         end
         S_BYTE: begin
            if (can_load) begin
               out_valid_d = 1'b1;
               out_data_d = item_byte(mem_val[scan_q[3:0]], sel_q);
               out_last_d = last_byte;
               idx_d = idx_q + 16'h0001;
               sel_d = sel_q + 2'h1;
               if (last_byte)
                  state_d = S_DRAIN;
               else if (sel_q == 2'h3) begin
                  scan_d = scan_q + 5'h01;
                  state_d = S_SCAN;
               end
            end
         end
         S_DRAIN: begin
            if (out_valid_q && out_ready)
               state_d = S_IDLE;
         end
         default: state_d = S_IDLE;
      endcase
   end

   always @(posedge ref_clk) begin
      if (take && !refuse) begin
         mem_val[n_q[3:0]] <= item_value;
         mem_op[n_q[3:0]] <= item_op;
      end
   end
   // synchronous reset folded into each register's next value, except the item store mem_val and mem_op, which has no reset
   always @(posedge ref_clk) begin
      state_q <= rst ? S_IDLE : state_d;
      fmt_q <= rst ? `FMT_REFRESH_WHOLE_STORE : fmt_d;
      floor_q <= rst ? `FLOOR_RESET : floor_d;
      n_q <= rst ? 5'h00 : n_d;
      scan_q <= rst ? 5'h00 : scan_d;
      op_q <= rst ? 2'h0 : op_d;
      sel_q <= rst ? 2'h0 : sel_d;
      idx_q <= rst ? 16'h0000 : idx_d;
      total_q <= rst ? `HEADER_BYTES : total_d;
      for (j = 0; j < 4; j = j + 1)
         cnt_q[j] <= rst ? `COUNT_RESET : cnt_d[j];
      fell_back_q <= rst ? 1'b0 : fell_back_d;
      item_err_q <= rst ? 1'b0 : item_err_d;
      out_valid_q <= rst ? 1'b0 : out_valid_d;
      out_last_q <= rst ? 1'b0 : out_last_d;
      out_data_q <= rst ? 8'h00 : out_data_d;
   end

endmodule

// ### test/change_event_props.sv
/*
 checker for the descriptor change event builder ports.
 assumes one clock and a synchronous active high reset; bound at the foot.
*/
`timescale 1ns/100ps
module change_event_props (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // composition
   input wire send,
   input wire busy,
   input wire fell_back_q,
   input wire item_valid,
   input wire item_ready,
   input wire item_err_q,
   // byte stream
   input wire out_valid_q,
   input wire [7:0] out_data_q,
   input wire out_last_q,
   input wire out_ready
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (rst);
   chk_reset_quiet:
   assert property ($fell(rst) |-> !out_valid_q && !item_err_q && !fell_back_q && !busy)
      else $error("outputs not idle after reset");
   chk_stall_hold:
   assert property (out_valid_q && !out_ready |=> out_valid_q && $stable(out_data_q)
      && $stable(out_last_q)) else $error("byte changed while stalled");
   chk_send_launch:
   assert property (item_ready ##1 send |=> busy ##1 out_valid_q)
      else $error("first byte not two edges after send");
   chk_last_ends:
   assert property (out_valid_q && out_ready && out_last_q |=> !busy && !out_valid_q)
      else $error("stream went on after last byte");
   chk_valid_busy:
   assert property (out_valid_q |-> busy) else $error("byte offered while not busy");
   chk_ready_idle:
   assert property (item_ready |-> !busy && !send) else $error("item taken outside fill");
   chk_fallback_zero:
   assert property (fell_back_q && out_valid_q |-> out_data_q == 8'h00)
      else $error("fallback payload not zero");
   chk_err_cause:
   assert property (item_err_q |-> $past(item_valid && item_ready))
      else $error("refusal flag without a taken item");
   chk_busy_drop:
   assert property ($fell(busy) |-> $past(out_valid_q && out_ready && out_last_q))
      else $error("busy fell before last byte taken");
   cover property (fell_back_q && out_valid_q);
   cover property (out_valid_q && !out_ready ##1 out_valid_q);
   cover property (item_err_q);
endmodule

bind descriptor_change_event_builder change_event_props change_event_props_i (
   .ref_clk(ref_clk), .rst(rst), .send(send), .busy(busy), .fell_back_q(fell_back_q),
   .item_valid(item_valid), .item_ready(item_ready), .item_err_q(item_err_q),
   .out_valid_q(out_valid_q), .out_data_q(out_data_q), .out_last_q(out_last_q),
   .out_ready(out_ready));

// ### test/event_receiver_model.sv
/*
 event receiver model: takes payload bytes into a store, optionally stalling.
 assumes the bench clears it before each message.
*/
`timescale 1ns/100ps
module event_receiver_model (
   // clock and reset
   input wire ref_clk,
   input wire rst,
   // bench control
   input wire slow,
   input wire clr,
   // payload stream
   input wire out_valid_q,
   input wire [7:0] out_data_q,
   input wire out_last_q,
   output logic out_ready,
   // received payload
   output logic [7:0] rx_mem [0:63],
   output logic [6:0] rx_n,
   output logic done
);
   // bytes kept in arrival order for field decoding
   always @(posedge ref_clk) begin
      // a slow receiver takes only every other cycle
      out_ready <= rst ? 1'b0 : (slow ? ~out_ready : 1'b1);
      if (rst || clr) begin
         rx_n <= 7'h00;
         done <= 1'b0;
      end else if (out_valid_q && out_ready) begin
         rx_mem[rx_n[5:0]] <= out_data_q;
         rx_n <= rx_n + 7'h01;
         done <= out_last_q;
      end
   end
endmodule

// ### test/descriptor_change_event_builder_tb_top.sv
/*
 testbench of the change event builder: message table, then awkward cases.
 assumes the receiver model and the bound checker are compiled beside it.
*/
`timescale 1ns/100ps
module descriptor_change_event_builder_tb_top;
   typedef struct {logic [7:0] fmt; int n; logic [7:0] ops; logic [127:0] vals;
      logic slow; int len;} row_t;
   logic ref_clk, rst, start, series_start, send, item_valid, slow, clr;
   logic [7:0] start_format;
   logic [1:0] item_op;
   logic [31:0] item_value;
   wire busy, fell_back_q, item_ready, item_err_q, out_valid_q, out_last_q, out_ready;
   wire [7:0] out_data_q;
   logic [7:0] rx_mem [0:63];
   logic [6:0] rx_n;
   logic done;
   int errors, compares, n_acc;
   logic [7:0] exp_q [$];
   logic [1:0] op_a [16], in_op [16];
   logic [31:0] val_a [16], in_val [16];
   logic [1:0] floor_q;
   row_t rows [4] = '{
      '{8'h00, 1, 8'h04, {96'h0, 32'h5}, 1'b0, 2},
      '{8'h01, 4, 8'h9c, {32'hc, 32'ha, 32'hb, 32'h11223344}, 1'b1, 26},
      '{8'h02, 3, 8'h06, {32'h0, 32'h7, 32'h01020304, 32'haabbccdd}, 1'b0, 14},
      '{8'h01, 2, 8'h00, {64'h0, 32'h6, 32'h5}, 1'b1, 12}};

   descriptor_change_event_builder descriptor_change_event_builder_i (.ref_clk(ref_clk),
      .rst(rst), .start(start), .start_format(start_format), .series_start(series_start),
      .send(send), .busy(busy), .fell_back_q(fell_back_q), .item_valid(item_valid),
      .item_op(item_op), .item_value(item_value), .item_ready(item_ready),
      .item_err_q(item_err_q), .out_valid_q(out_valid_q), .out_data_q(out_data_q),
      .out_last_q(out_last_q), .out_ready(out_ready));
   event_receiver_model event_receiver_model_i (.ref_clk(ref_clk), .rst(rst), .slow(slow),
      .clr(clr), .out_valid_q(out_valid_q), .out_data_q(out_data_q),
      .out_last_q(out_last_q), .out_ready(out_ready), .rx_mem(rx_mem), .rx_n(rx_n),
      .done(done));

   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end

   task automatic check(input logic ok, input string what);
      compares++;
      if (ok !== 1'b1) begin
         errors++;
         $display("mismatch at %0t: %s", $time, what);
      end
   endtask

   task automatic give_verdict;
      if (errors == 0 && compares > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic give_item(input logic [1:0] op, input logic [31:0] val);
      logic bad;
      bad = start_format == 8'h00 || (op == 2'h0 && start_format != 8'h01)
         || (op != 2'h0 && op < floor_q);
      check(item_ready, "item not accepted");
      item_valid = 1'b1;
      item_op = op;
      item_value = val;
      @(negedge ref_clk);
      check(item_err_q === bad, "refusal flag");
      if (!bad) begin
         op_a[n_acc] = op;
         val_a[n_acc] = val;
         n_acc++;
      end
   endtask

   task automatic run_msg(input logic [7:0] fmt, input logic ser, input int n);
      int cnt [4];
      int ng, sz, k;
      logic fb;
      series_start = ser;
      if (ser) floor_q = 2'h1;
      start = 1'b1;
      start_format = fmt;
      clr = 1'b1;
      @(negedge ref_clk);
      {start, series_start, clr} = 3'h0;
      n_acc = 0;
      for (int i = 0; i < n; i++) give_item(in_op[i], in_val[i]);
      item_valid = 1'b0;
      send = 1'b1;
      @(negedge ref_clk);
      send = 1'b0;
      cnt = '{0, 0, 0, 0};
      for (int j = 0; j < n_acc; j++) cnt[op_a[j]]++;
      sz = 2;
      ng = 0;
      for (int o = 0; o < 4; o++) if (cnt[o] > 0) begin
         ng++;
         sz += 2 + 4 * cnt[o];
      end
      fb = fmt != 8'h00 && sz > 60;
      exp_q.delete();
      exp_q.push_back(fb ? 8'h00 : fmt);
      exp_q.push_back((fmt == 8'h00 || fb) ? 8'h00 : 8'(ng));
      for (int o = 0; o < 4 && !fb; o++) if (cnt[o] > 0) begin
         exp_q.push_back(8'(o));
         exp_q.push_back(8'(cnt[o]));
         for (int j = 0; j < n_acc; j++) if (op_a[j] == o)
            for (int b = 0; b < 4; b++) exp_q.push_back(val_a[j][8*b+:8]);
      end
      for (int o = 1; o < 4 && !fb; o++) if (cnt[o] > 0 && o > floor_q) floor_q = 2'(o);
      for (k = 0; k < 400 && !(done && !busy); k++) @(negedge ref_clk);
      if (!(done === 1'b1 && busy === 1'b0)) begin
         errors++;
         $display("mismatch at %0t: payload never completed", $time);
         return;
      end
      check(rx_n === 7'(exp_q.size()), "payload length");
      for (int i = 0; i < exp_q.size(); i++)
         check(rx_mem[i] === exp_q[i], "payload byte");
      check(fell_back_q === fb, "fallback flag");
   endtask

   initial begin
      {rst, start, series_start, send, item_valid, slow, clr} = 7'h41;
      start_format = 8'h00;
      item_op = 2'h0;
      item_value = 32'h0;
      floor_q = 2'h1;
      repeat (6) @(negedge ref_clk);
      check(!out_valid_q && !busy && !item_ready && !item_err_q && !fell_back_q, "reset");
      rst = 1'b0;
      foreach (rows[r]) begin
         for (int i = 0; i < 4; i++) begin
            in_op[i] = rows[r].ops[2*i+:2];
            in_val[i] = rows[r].vals[32*i+:32];
         end
         slow = rows[r].slow;
         run_msg(rows[r].fmt, 1'b1, rows[r].n);
         check(rx_n === 7'(rows[r].len), "table length");
      end
      in_op[0] = 2'h2;
      in_val[0] = 32'h00000042;
      run_msg(8'h02, 1'b1, 1);
      in_op[0] = 2'h1;
      run_msg(8'h02, 1'b0, 1);
      run_msg(8'h02, 1'b1, 1);
      for (int i = 0; i < 15; i++) begin
         in_op[i] = 2'h1;
         in_val[i] = 32'(i);
      end
      run_msg(8'h02, 1'b1, 15);
      // reset in mid-emission: back to idle, category floor back to deleted
      in_op[0] = 2'h3;
      run_msg(8'h02, 1'b1, 1);
      start = 1'b1;
      @(negedge ref_clk);
      start = 1'b0;
      give_item(2'h3, 32'h00000077);
      {item_valid, send} = 2'h1;
      @(negedge ref_clk);
      send = 1'b0;
      repeat (2) @(negedge ref_clk);
      rst = 1'b1;
      repeat (2) @(negedge ref_clk);
      check(!busy && !out_valid_q && !out_last_q && out_data_q === 8'h00 && !item_ready,
         "mid-run reset");
      rst = 1'b0;
      floor_q = 2'h1;
      in_op[0] = 2'h1;
      run_msg(8'h02, 1'b0, 1);
      give_verdict();
   end
endmodule
